// [hw/smlf_field.v]
// One read-write register field with reset value and write strobe
`timescale 1ns/1ps

module smlf_field #(
    parameter WIDTH = 1,
    parameter [WIDTH-1:0] RESET_VALUE = {WIDTH{1'b0}}
) (
    input wire clk_in,
    input wire reset_in,
    input wire write_in,
    input wire [WIDTH-1:0] data_in,
    output reg [WIDTH-1:0] value_out
);

    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            value_out <= RESET_VALUE;
        end else if (write_in) begin
            value_out <= data_in;
        end
    end

endmodule

// [hw/smlf_regs.v]
// Modulator and loop filter configuration registers of the second synthesizer
`timescale 1ns/1ps
`include "smlf_regs_map.vh"

// Functional notes
// - Dither select bits 3:2, reset 3=off
// - Order bits 1:0, reset 0=integer
// - R2 code bits 5:0, reset 0x24
// - C1 code bits 2:0, reset zero
// - C3 code bits 2:0, reset zero
// - R3 code bits 6:1, reset zero
module smlf_regs (
    input wire clk_in,
    input wire reset_in,
    input wire [`SMLF_ADDR_W-1:0] addr_in,
    input wire [`SMLF_DATA_W-1:0] wdata_in,
    input wire write_in,
    input wire read_in,
    output reg [`SMLF_DATA_W-1:0] rdata_out,
    output reg [1:0] modulator_dither_select_out,
    output reg [1:0] modulator_order_select_out,
    output reg dither_enable_out,
    output reg frac_divider_enable_out,
    output reg [5:0] loop_resistor_two_out,
    output reg [2:0] loop_capacitor_one_out,
    output reg [5:0] loop_resistor_three_out,
    output reg loop_filter_frac_select_out,
    output reg [2:0] loop_capacitor_three_out
);

    // Exact address match; writes to unmapped addresses store nothing
    wire wr_mod = write_in && (addr_in == `SMLF_OFF_MOD_CTRL);
    wire wr_r2 = write_in && (addr_in == `SMLF_OFF_RES_TWO);
    wire wr_c1 = write_in && (addr_in == `SMLF_OFF_CAP_ONE);
    wire wr_r3 = write_in && (addr_in == `SMLF_OFF_RES_THREE);
    wire wr_c3 = write_in && (addr_in == `SMLF_OFF_CAP_THREE);

    // Widths follow the bit positions, so the map header stays the one source
    localparam DITHER_W = `SMLF_DITHER_HI - `SMLF_DITHER_LO + 1;
    localparam ORDER_W = `SMLF_ORDER_HI - `SMLF_ORDER_LO + 1;
    localparam RES_TWO_W = `SMLF_RES_TWO_HI - `SMLF_RES_TWO_LO + 1;
    localparam CAP_W = `SMLF_CAP_HI - `SMLF_CAP_LO + 1;
    localparam RES_THREE_W = `SMLF_RES_THREE_HI - `SMLF_RES_THREE_LO + 1;

    wire [DITHER_W-1:0] dither;
    wire [ORDER_W-1:0] order;
    wire [RES_TWO_W-1:0] res_two;
    wire [CAP_W-1:0] cap_one;
    wire [RES_THREE_W-1:0] res_three;
    wire frac_sel;
    wire [CAP_W-1:0] cap_three;

    // Only field bits are stored; reserved bits have no flops
    smlf_field #(.WIDTH(DITHER_W), .RESET_VALUE(`SMLF_DITHER_RST)) u_dither (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .write_in(wr_mod),
        .data_in(wdata_in[`SMLF_DITHER_HI:`SMLF_DITHER_LO]),
        .value_out(dither)
    );

    smlf_field #(.WIDTH(ORDER_W), .RESET_VALUE(`SMLF_ORDER_RST)) u_order (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .write_in(wr_mod),
        .data_in(wdata_in[`SMLF_ORDER_HI:`SMLF_ORDER_LO]),
        .value_out(order)
    );

    smlf_field #(.WIDTH(RES_TWO_W), .RESET_VALUE(`SMLF_RES_TWO_RST)) u_res_two (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .write_in(wr_r2),
        .data_in(wdata_in[`SMLF_RES_TWO_HI:`SMLF_RES_TWO_LO]),
        .value_out(res_two)
    );

    smlf_field #(.WIDTH(CAP_W), .RESET_VALUE(`SMLF_CAP_ONE_RST)) u_cap_one (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .write_in(wr_c1),
        .data_in(wdata_in[`SMLF_CAP_HI:`SMLF_CAP_LO]),
        .value_out(cap_one)
    );

    smlf_field #(.WIDTH(RES_THREE_W), .RESET_VALUE(`SMLF_RES_THREE_RST)) u_res_three (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .write_in(wr_r3),
        .data_in(wdata_in[`SMLF_RES_THREE_HI:`SMLF_RES_THREE_LO]),
        .value_out(res_three)
    );

    // Mode bit is stored as written; matching it to the order is software's job
    smlf_field #(.WIDTH(1), .RESET_VALUE(`SMLF_FRAC_RST)) u_frac (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .write_in(wr_r3),
        .data_in(wdata_in[`SMLF_FRAC_BIT]),
        .value_out(frac_sel)
    );

    smlf_field #(.WIDTH(CAP_W), .RESET_VALUE(`SMLF_CAP_THREE_RST)) u_cap_three (
        .clk_in(clk_in),
        .reset_in(reset_in),
        .write_in(wr_c3),
        .data_in(wdata_in[`SMLF_CAP_HI:`SMLF_CAP_LO]),
        .value_out(cap_three)
    );

    reg [`SMLF_DATA_W-1:0] image_mod;
    reg [`SMLF_DATA_W-1:0] image_res_two;
    reg [`SMLF_DATA_W-1:0] image_cap_one;
    reg [`SMLF_DATA_W-1:0] image_res_three;
    reg [`SMLF_DATA_W-1:0] image_cap_three;
    reg [`SMLF_DATA_W-1:0] next_rdata;
    reg [`SMLF_DATA_W-1:0] next_read_word;
    reg next_dither_enable;
    reg next_frac_enable;

    // Each image starts from zero, so reserved positions always read zero
    always @* begin
        image_mod = `SMLF_READ_ZERO;
        image_mod[`SMLF_DITHER_HI:`SMLF_DITHER_LO] = dither;
        image_mod[`SMLF_ORDER_HI:`SMLF_ORDER_LO] = order;
    end

    always @* begin
        image_res_two = `SMLF_READ_ZERO;
        image_res_two[`SMLF_RES_TWO_HI:`SMLF_RES_TWO_LO] = res_two;
    end

    always @* begin
        image_cap_one = `SMLF_READ_ZERO;
        image_cap_one[`SMLF_CAP_HI:`SMLF_CAP_LO] = cap_one;
    end

    always @* begin
        image_res_three = `SMLF_READ_ZERO;
        image_res_three[`SMLF_RES_THREE_HI:`SMLF_RES_THREE_LO] = res_three;
        image_res_three[`SMLF_FRAC_BIT] = frac_sel;
    end

    always @* begin
        image_cap_three = `SMLF_READ_ZERO;
        image_cap_three[`SMLF_CAP_HI:`SMLF_CAP_LO] = cap_three;
    end

    // Unmapped addresses fall to the default and read zero
    always @* begin
        next_rdata = `SMLF_READ_ZERO;
        case (addr_in)
            `SMLF_OFF_MOD_CTRL: begin
                next_rdata = image_mod;
            end
            `SMLF_OFF_RES_TWO: begin
                next_rdata = image_res_two;
            end
            `SMLF_OFF_CAP_ONE: begin
                next_rdata = image_cap_one;
            end
            `SMLF_OFF_RES_THREE: begin
                next_rdata = image_res_three;
            end
            `SMLF_OFF_CAP_THREE: begin
                next_rdata = image_cap_three;
            end
            default: begin
                next_rdata = `SMLF_READ_ZERO;
            end
        endcase
    end

    // Enables decoded ahead of the output flops so every output is a plain register
    always @* begin
        next_dither_enable = (dither != `SMLF_DITHER_OFF);
        next_frac_enable = (order != `SMLF_ORDER_INT);
        next_read_word = `SMLF_READ_ZERO;
        if (read_in) begin
            next_read_word = next_rdata;
        end
    end

    // Read data stand for the cycle after each read_in cycle, then fall back to zero
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            rdata_out <= `SMLF_READ_ZERO;
        end else begin
            rdata_out <= next_read_word;
        end
    end

    // Modulator outputs lag the stored fields by one cycle; reset mirrors the fields
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            modulator_dither_select_out <= `SMLF_DITHER_RST;
            modulator_order_select_out <= `SMLF_ORDER_RST;
            dither_enable_out <= (`SMLF_DITHER_RST != `SMLF_DITHER_OFF);
            frac_divider_enable_out <= (`SMLF_ORDER_RST != `SMLF_ORDER_INT);
        end else begin
            modulator_dither_select_out <= dither;
            modulator_order_select_out <= order;
            dither_enable_out <= next_dither_enable;
            frac_divider_enable_out <= next_frac_enable;
        end
    end

    // Trim codes re-registered so the analog side only sees flop-driven levels
    always @(posedge clk_in or posedge reset_in) begin
        if (reset_in) begin
            loop_resistor_two_out <= `SMLF_RES_TWO_RST;
            loop_capacitor_one_out <= `SMLF_CAP_ONE_RST;
            loop_resistor_three_out <= `SMLF_RES_THREE_RST;
            loop_filter_frac_select_out <= `SMLF_FRAC_RST;
            loop_capacitor_three_out <= `SMLF_CAP_THREE_RST;
        end else begin
            loop_resistor_two_out <= res_two;
            loop_capacitor_one_out <= cap_one;
            loop_resistor_three_out <= res_three;
            loop_filter_frac_select_out <= frac_sel;
            loop_capacitor_three_out <= cap_three;
        end
    end

endmodule

// [hw/smlf_regs_map.vh]
// Register offsets, field positions and reset values for the loop filter register group
`ifndef SMLF_REGS_MAP_VH
`define SMLF_REGS_MAP_VH

`define SMLF_ADDR_W 8
`define SMLF_DATA_W 8

`define SMLF_OFF_MOD_CTRL 8'h51
`define SMLF_OFF_RES_TWO 8'h52
`define SMLF_OFF_CAP_ONE 8'h53
`define SMLF_OFF_RES_THREE 8'h54
`define SMLF_OFF_CAP_THREE 8'h55

`define SMLF_DITHER_HI 3
`define SMLF_DITHER_LO 2
`define SMLF_ORDER_HI 1
`define SMLF_ORDER_LO 0
`define SMLF_RES_TWO_HI 5
`define SMLF_RES_TWO_LO 0
`define SMLF_CAP_HI 2
`define SMLF_CAP_LO 0
`define SMLF_RES_THREE_HI 6
`define SMLF_RES_THREE_LO 1
`define SMLF_FRAC_BIT 0

`define SMLF_DITHER_RST 2'h3
`define SMLF_ORDER_RST 2'h0
`define SMLF_RES_TWO_RST 6'h24
`define SMLF_CAP_ONE_RST 3'h0
`define SMLF_CAP_THREE_RST 3'h0
`define SMLF_RES_THREE_RST 6'h00
`define SMLF_FRAC_RST 1'h0

`define SMLF_DITHER_OFF 2'h3
`define SMLF_ORDER_INT 2'h0
`define SMLF_READ_ZERO 8'h00

`endif

// [verification/smlf_regs_bench.sv]
// Self-checking bench for the loop filter register group
`timescale 1ns/1ps
module smlf_regs_bench;
    logic clk_in = 0;
    logic reset_in = 1;
    logic write_in = 0;
    logic read_in = 0;
    logic [7:0] addr_in = 0;
    logic [7:0] wdata_in = 0;
    wire [7:0] rdo;
    wire [1:0] ds, os;
    wire de, fe, fs;
    wire [5:0] r2, r3;
    wire [2:0] c1, c3;
    int fails = 0;
    int compares = 0;
    // Address, write data, expected read back; last row is unmapped
    logic [23:0] rows [0:10] = '{24'h51ff0f, 24'h510404, 24'h510909, 24'h510202, 24'h52ff3f,
        24'h523030, 24'h53ff07, 24'h54ff7f, 24'h544141, 24'h55ff07, 24'h5aff00};
    smlf_regs dut (.clk_in(clk_in), .reset_in(reset_in), .addr_in(addr_in), .wdata_in(wdata_in),
        .write_in(write_in), .read_in(read_in),
        .rdata_out(rdo), .modulator_dither_select_out(ds), .modulator_order_select_out(os),
        .dither_enable_out(de), .frac_divider_enable_out(fe), .loop_resistor_two_out(r2),
        .loop_capacitor_one_out(c1), .loop_resistor_three_out(r3),
        .loop_filter_frac_select_out(fs), .loop_capacitor_three_out(c3));
    initial forever #4 clk_in = ~clk_in;
    task chk(input string n, input logic [7:0] e, input logic [7:0] g);
        compares++;
        if (g !== e) begin
            fails++;
            $display("mismatch %s exp %h got %h", n, e, g);
        end
    endtask
    task strobe(input logic w, input logic [7:0] a, input logic [7:0] d);
        @(posedge clk_in);
        write_in <= w;
        read_in <= !w;
        addr_in <= a;
        wdata_in <= d;
    endtask
    task rd(input logic [7:0] a, input logic [7:0] e);
        strobe(0, a, 0);
        @(posedge clk_in);
        read_in <= 0;
        #1 chk("read data", e, rdo);
    endtask
    task test_done;
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    initial begin
        #20000;
        fails++;
        test_done;
    end
    initial begin
        repeat (20) @(posedge clk_in);
        reset_in <= 0;
        #1 chk("ctrl outputs", 8'h0c, {de, fe, ds, os});
        chk("r2 output", 8'h24, {2'h0, r2});
        chk("c1 c3 r3", 8'h00, {c1, c3} | {r3, fs});
        rd(8'h52, 8'h24);
        $display("test reset done");
        foreach (rows[i]) begin
            // Read straight after write, reserved bits set in most rows
            strobe(1, rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16], rows[i][7:0]);
        end
        chk("fields", 8'h3f, {2'h0, c1, c3});
        chk("r3 frac", 8'h41, {1'h0, r3, fs});
        $display("test rows done");
        strobe(1, 8'h51, 8'h06);
        @(posedge clk_in);
        write_in <= 0;
        @(posedge clk_in);
        #1 chk("ctrl outputs", 8'h36, {de, fe, ds, os});
        // Mid-run reset, raised and dropped on clock edges
        @(posedge clk_in);
        reset_in <= 1;
        #1 chk("ctrl outputs", 8'h0c, {de, fe, ds, os});
        chk("r2 output", 8'h24, {2'h0, r2});
        @(posedge clk_in);
        reset_in <= 0;
        rd(8'h51, 8'h0c);
        rd(8'h54, 8'h00);
        $display("test second reset done");
        test_done;
    end
endmodule

// [verification/smlf_regs_chk.sv]
// Port-level checker for the loop filter register group
`timescale 1ns/1ps
module smlf_regs_chk (
    input wire clk_in,
    input wire reset_in,
    input wire [7:0] addr_in,
    input wire [7:0] wdata_in,
    input wire write_in,
    input wire read_in,
    input wire [7:0] rdata_out,
    input wire [1:0] modulator_dither_select_out,
    input wire [1:0] modulator_order_select_out,
    input wire dither_enable_out,
    input wire frac_divider_enable_out,
    input wire [5:0] loop_resistor_two_out,
    input wire [2:0] loop_capacitor_one_out,
    input wire [5:0] loop_resistor_three_out,
    input wire loop_filter_frac_select_out,
    input wire [2:0] loop_capacitor_three_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    a_mod_write: assert property (write_in && addr_in == 8'h51 |=> ##1
        {modulator_dither_select_out, modulator_order_select_out} == $past(wdata_in[3:0], 2))
        else $error("control field not loaded");
    a_res_two_write: assert property (write_in && addr_in == 8'h52 |=> ##1
        loop_resistor_two_out == $past(wdata_in[5:0], 2)) else $error("r2 not loaded");
    a_cap_one_write: assert property (write_in && addr_in == 8'h53 |=> ##1
        loop_capacitor_one_out == $past(wdata_in[2:0], 2)) else $error("c1 not loaded");
    a_res_three_write: assert property (write_in && addr_in == 8'h54 |=> ##1
        {loop_resistor_three_out, loop_filter_frac_select_out} == $past(wdata_in[6:0], 2))
        else $error("r3 not loaded");
    a_cap_three_write: assert property (write_in && addr_in == 8'h55 |=> ##1
        loop_capacitor_three_out == $past(wdata_in[2:0], 2)) else $error("c3 not loaded");
    a_enable_derive: assert property (
        dither_enable_out == (modulator_dither_select_out != 2'h3)
        && frac_divider_enable_out == (modulator_order_select_out != 2'h0))
        else $error("enables wrong");
    a_idle_rdata: assert property (!read_in |=> rdata_out == 8'h00)
        else $error("read data not idle");
    a_ctrl_read: assert property (read_in && addr_in == 8'h51 |=> rdata_out ==
        {4'h0, modulator_dither_select_out, modulator_order_select_out}) else $error("bad read");
endmodule

bind smlf_regs smlf_regs_chk chk (
    .clk_in(clk_in),
    .reset_in(reset_in),
    .addr_in(addr_in),
    .wdata_in(wdata_in),
    .write_in(write_in),
    .read_in(read_in),
    .rdata_out(rdata_out),
    .modulator_dither_select_out(modulator_dither_select_out),
    .modulator_order_select_out(modulator_order_select_out),
    .dither_enable_out(dither_enable_out),
    .frac_divider_enable_out(frac_divider_enable_out),
    .loop_resistor_two_out(loop_resistor_two_out),
    .loop_capacitor_one_out(loop_capacitor_one_out),
    .loop_resistor_three_out(loop_resistor_three_out),
    .loop_filter_frac_select_out(loop_filter_frac_select_out),
    .loop_capacitor_three_out(loop_capacitor_three_out)
);
